// File: hw/cssc_pkg.sv
// Constants and types shared by the clock source and start-up control block
package cssc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W = 24;
	// Reset time-out figures in microseconds and their cycle counts
	localparam int TOUT_4P1MS_US = 4100;
	localparam int TOUT_65MS_US = 65000;
	localparam int TOUT_4MS_US = 4000;
	localparam int TOUT_64MS_US = 64000;
	localparam int TOUT_4P1MS_CYC = (TOUT_4P1MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOUT_65MS_CYC = (TOUT_65MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOUT_4MS_CYC = (TOUT_4MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOUT_64MS_CYC = (TOUT_64MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Source clock cycle counts
	localparam int RST_CK_LF = 4;
	localparam int RST_CK_STD = 14;
	localparam int WAKE_CK_STD = 6;
	localparam int WAKE_CK_LF_SHORT = 1024;
	localparam int WAKE_CK_LF_LONG = 32768;
	// Fuse encodings
	localparam logic [3:0] SRC_CODE_EXT = 4'h0;
	localparam logic [3:0] SRC_CODE_RC = 4'h2;
	localparam logic [3:0] SRC_CODE_128K = 4'h3;
	localparam logic [2:0] SRC_CODE_LF_HI = 3'h3;
	localparam logic [1:0] STARTUP_SHORT = 2'h0;
	localparam logic [1:0] STARTUP_MID = 2'h1;
	localparam logic [1:0] STARTUP_FACTORY = 2'h2;
	// Prescaler
	localparam logic [3:0] PS_DIV1 = 4'h0;
	localparam logic [3:0] PS_FUSE_DIV8 = 4'h3;
	localparam logic [3:0] PS_MAX = 4'h8;
	localparam logic [2:0] PCE_TIMEOUT = 3'h4;
	localparam int PCE_BIT = 7;
	localparam int ASYNC_EXT_CLK_BIT = 0;
	localparam int ASYNC_EN_BIT = 1;
	// Register byte offsets
	localparam logic [7:0] ADDR_OSC_TRIM = 8'h00;
	localparam logic [7:0] ADDR_PRESCALE = 8'h04;
	localparam logic [7:0] ADDR_ASYNC = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] TRIM_RST = 8'h80;
	typedef enum logic [3:0] {
		SRC_EXT = 4'b0001,
		SRC_RC = 4'b0010,
		SRC_128K = 4'b0100,
		SRC_LF = 4'b1000
	} cssc_src_t;
	typedef enum logic [4:0] {
		ST_LOAD = 5'b00001,
		ST_DELAY = 5'b00010,
		ST_RUN = 5'b00100,
		ST_SLEEP = 5'b01000,
		ST_WAKE = 5'b10000
	} cssc_state_t;
endpackage : cssc_pkg

// File: hw/cssc_down_counter.sv
// Loadable down counter with a registered done flag
`timescale 1ns/1ns
`default_nettype none
module cssc_down_counter #(
	parameter int W = 24
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	input wire logic i_step,
	output logic o_done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} cssc_cnt_t;
	cssc_cnt_t s;
	cssc_cnt_t n;

	always_comb begin
		n = s;
		if (i_load) begin
			n.cnt = i_value;
			n.done = (i_value == '0);
		end else if (i_step && s.cnt != '0) begin
			n.cnt = s.cnt - 1'b1;
			n.done = (s.cnt == W'(1));
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_done = s.done;
endmodule : cssc_down_counter
`default_nettype wire

// File: hw/cssc_prescaler.sv
// System clock prescaler: divide-by-2^n enable and clock pin toggle
`timescale 1ns/1ns
`default_nettype none
module cssc_prescaler
	import cssc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [3:0] i_sel,
	output logic o_tick,
	output logic o_clk,
	output logic [3:0] o_applied
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [3:0] applied;
		logic clk;
	} cssc_ps_t;
	cssc_ps_t s;
	cssc_ps_t n;
	logic [8:0] full;
	logic [7:0] mask;
	logic [3:0] sel_eff;

	// Reserved codes divide as the largest factor
	assign sel_eff = (i_sel > PS_MAX) ? PS_MAX : i_sel;
	assign full = 9'(9'h001 << s.applied) - 9'h001;
	assign mask = full[7:0];
	assign o_tick = (s.cnt == mask);

	always_comb begin
		n = s;
		n.cnt = s.cnt + 8'h01;
		// New factor only at a period boundary, so no short period
		if (o_tick) begin
			n.cnt = 8'h00;
			n.applied = sel_eff;
			n.clk = ~s.clk;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_clk = s.clk;
	assign o_applied = s.applied;

	property p_ps_boundary;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(s.applied != $past(s.applied)) |-> $past(o_tick);
	endproperty
	a_ps_boundary: assert property (p_ps_boundary)
		else $error("Prescale factor changed inside a period");
endmodule : cssc_prescaler
`default_nettype wire

// File: hw/cssc_clock_startup.sv
// Clock source select, start-up timing and prescale control with AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module cssc_clock_startup
	import cssc_pkg::*;
#(
	parameter logic [CNT_W-1:0] P_TOUT_SHORT_CYC = CNT_W'(TOUT_4P1MS_CYC),
	parameter logic [CNT_W-1:0] P_TOUT_LONG_CYC = CNT_W'(TOUT_65MS_CYC),
	parameter logic [CNT_W-1:0] P_TOUT_128K_SHORT_CYC = CNT_W'(TOUT_4MS_CYC),
	parameter logic [CNT_W-1:0] P_TOUT_128K_LONG_CYC = CNT_W'(TOUT_64MS_CYC),
	parameter logic [CNT_W-1:0] P_WAKE_LONG_CK = CNT_W'(WAKE_CK_LF_LONG)
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [3:0] i_clock_source_select_fuses,
	input wire logic [1:0] i_startup_time_fuses,
	input wire logic i_divide_by_eight_fuse,
	input wire logic i_reset_pin_disable_fuse,
	input wire logic i_clock_output_fuse,
	input wire logic [7:0] i_factory_cal,
	input wire logic i_wdt_osc_tick,
	input wire logic i_power_down,
	input wire logic i_port_out,
	input wire logic i_port_oe_n,
	output logic [3:0] o_source_sel,
	output logic [7:0] o_osc_trim,
	output logic o_internal_reset_n,
	output logic o_sys_clk_en,
	output logic o_clock_output_pin,
	output logic o_clock_output_pin_oe_n,
	output logic o_timer_osc_en,
	output logic o_timer_ext_clk
);
	typedef struct packed {
		cssc_state_t state;
		logic rst_n;
		cssc_src_t src;
		logic a_valid;
		logic a_write;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic [7:0] trim;
		logic [3:0] ps;
		logic pce;
		logic [2:0] pce_cnt;
		logic ext_clk;
		logic tmr_en;
		logic [3:0] src_code;
		logic [1:0] su_code;
		logic rstdis;
	} cssc_main_t;
	cssc_main_t s;
	cssc_main_t n;

	logic load_st;
	logic sleep_st;
	logic a_take;
	logic wr;
	logic [3:0] cur_cs;
	logic [1:0] cur_su;
	logic cur_rd;
	logic ck_load;
	logic [CNT_W-1:0] ck_value;
	logic [CNT_W-1:0] tout_value;
	logic ck_done;
	logic tout_done;
	logic tick;
	logic pin_clk;
	logic [3:0] applied_ps;
	logic timer_act;

	function automatic cssc_src_t src_of(input logic [3:0] cs);
		cssc_src_t r;
		r = SRC_RC;
		if (cs == SRC_CODE_EXT) begin
			r = SRC_EXT;
		end else if (cs == SRC_CODE_RC) begin
			r = SRC_RC;
		end else if (cs == SRC_CODE_128K) begin
			r = SRC_128K;
		end else if (cs[3:1] == SRC_CODE_LF_HI) begin
			r = SRC_LF;
		end
		return r;
	endfunction : src_of

	function automatic logic [CNT_W-1:0] rst_ck_of(input logic [3:0] cs);
		logic [CNT_W-1:0] r;
		r = CNT_W'(RST_CK_STD);
		if (src_of(cs) == SRC_LF) begin
			r = CNT_W'(RST_CK_LF);
		end
		return r;
	endfunction : rst_ck_of

	function automatic logic [CNT_W-1:0] wake_of(input logic [3:0] cs);
		logic [CNT_W-1:0] r;
		r = CNT_W'(WAKE_CK_STD);
		if (src_of(cs) == SRC_LF) begin
			r = cs[0] ? P_WAKE_LONG_CK : CNT_W'(WAKE_CK_LF_SHORT);
		end
		return r;
	endfunction : wake_of

	// Reserved start-up code 11 is treated like the longest setting
	function automatic logic [CNT_W-1:0] tout_of(input logic [3:0] cs,
		input logic [1:0] su, input logic rd);
		logic [CNT_W-1:0] r;
		logic lf;
		lf = (src_of(cs) == SRC_LF);
		r = '0;
		if (su == STARTUP_MID) begin
			r = (src_of(cs) == SRC_128K) ? P_TOUT_128K_SHORT_CYC
				: P_TOUT_SHORT_CYC;
		end else if (su != STARTUP_SHORT) begin
			r = (src_of(cs) == SRC_128K) ? P_TOUT_128K_LONG_CYC
				: P_TOUT_LONG_CYC;
		end
		if (rd && su == STARTUP_SHORT && !lf) begin
			r = P_TOUT_SHORT_CYC;
		end
		return r;
	endfunction : tout_of

	function automatic logic [31:0] read_word(input logic [7:0] a,
		input cssc_main_t st, input logic [3:0] ap, input logic ta);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (a)
			ADDR_OSC_TRIM: r = {24'h000000, st.trim};
			ADDR_PRESCALE: r = {24'h000000, st.pce, 3'h0, st.ps};
			ADDR_ASYNC: r = {30'h00000000, st.tmr_en, st.ext_clk};
			ADDR_STATUS: r = {20'h00000, ap, 2'h0, ta, st.rst_n, st.src};
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction : read_word

	assign load_st = (s.state == ST_LOAD);
	assign sleep_st = (s.state == ST_SLEEP);
	assign cur_cs = load_st ? i_clock_source_select_fuses : s.src_code;
	assign cur_su = load_st ? i_startup_time_fuses : s.su_code;
	assign cur_rd = load_st ? i_reset_pin_disable_fuse : s.rstdis;
	assign ck_load = load_st || (sleep_st && !i_power_down);
	assign ck_value = load_st ? rst_ck_of(cur_cs) : wake_of(s.src_code);
	assign tout_value = tout_of(cur_cs, cur_su, cur_rd);
	assign a_take = i_hsel && i_htrans[1] && i_hready;
	assign wr = s.a_valid && s.a_write;
	assign timer_act = s.tmr_en && (s.src == SRC_RC);

	cssc_down_counter #(
		.W(CNT_W)
	) u_ck_cnt (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_load(ck_load),
		.i_value(ck_value),
		.i_step(1'b1),
		.o_done(ck_done)
	);

	// Time-out runs on the watchdog oscillator, not the selected source
	cssc_down_counter #(
		.W(CNT_W)
	) u_tout_cnt (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_load(load_st),
		.i_value(tout_value),
		.i_step(i_wdt_osc_tick),
		.o_done(tout_done)
	);

	cssc_prescaler u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_sel(s.ps),
		.o_tick(tick),
		.o_clk(pin_clk),
		.o_applied(applied_ps)
	);

	always_comb begin
		n = s;
		n.a_valid = a_take;
		if (a_take) begin
			n.a_write = i_hwrite;
			n.a_addr = i_haddr[7:0];
			if (!i_hwrite) begin
				n.hrdata = read_word(i_haddr[7:0], s, applied_ps, timer_act);
			end
		end
		// Change enable expires on its own; rewriting does not extend it
		if (s.pce) begin
			n.pce_cnt = s.pce_cnt - 3'h1;
			if (s.pce_cnt == 3'h1) begin
				n.pce = 1'b0;
			end
		end
		if (wr) begin
			unique case (s.a_addr)
				ADDR_OSC_TRIM: n.trim = i_hwdata[7:0];
				ADDR_PRESCALE: begin
					if (i_hwdata[PCE_BIT] && i_hwdata[6:0] == 7'h00) begin
						if (!s.pce) begin
							n.pce = 1'b1;
							n.pce_cnt = PCE_TIMEOUT;
						end
					end else if (!i_hwdata[PCE_BIT] && s.pce) begin
						n.ps = i_hwdata[3:0];
						n.pce = 1'b0;
					end
				end
				ADDR_ASYNC: begin
					n.ext_clk = i_hwdata[ASYNC_EXT_CLK_BIT];
					n.tmr_en = i_hwdata[ASYNC_EN_BIT];
				end
				default: n.trim = s.trim;
			endcase
		end
		unique case (s.state)
			ST_LOAD: begin
				n.src_code = i_clock_source_select_fuses;
				n.su_code = i_startup_time_fuses;
				n.rstdis = i_reset_pin_disable_fuse;
				n.src = src_of(i_clock_source_select_fuses);
				n.trim = i_factory_cal;
				n.ps = i_divide_by_eight_fuse ? PS_FUSE_DIV8 : PS_DIV1;
				n.pce = 1'b0;
				n.state = ST_DELAY;
			end
			ST_DELAY: begin
				if (ck_done && tout_done) begin
					n.state = ST_RUN;
					n.rst_n = 1'b1;
				end
			end
			ST_RUN: begin
				if (i_power_down) begin
					n.state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!i_power_down) begin
					n.state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (ck_done) begin
					n.state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s.state <= ST_LOAD;
			s.rst_n <= 1'b0;
			s.src <= SRC_RC;
			s.a_valid <= 1'b0;
			s.a_write <= 1'b0;
			s.a_addr <= 8'h00;
			s.hrdata <= 32'h00000000;
			s.trim <= TRIM_RST;
			s.ps <= PS_DIV1;
			s.pce <= 1'b0;
			s.pce_cnt <= 3'h0;
			s.ext_clk <= 1'b0;
			s.tmr_en <= 1'b0;
			s.src_code <= SRC_CODE_RC;
			s.su_code <= STARTUP_FACTORY;
			s.rstdis <= 1'b0;
		end else begin
			s <= n;
		end
	end

	assign o_hrdata = s.hrdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_source_sel = s.src;
	assign o_osc_trim = s.trim;
	assign o_internal_reset_n = s.rst_n;
	// Processor clock enable follows the prescaler for any source
	assign o_sys_clk_en = tick && (s.state == ST_RUN);
	assign o_clock_output_pin = i_clock_output_fuse ? pin_clk : i_port_out;
	assign o_clock_output_pin_oe_n = i_clock_output_fuse ? 1'b0 : i_port_oe_n;
	assign o_timer_osc_en = timer_act;
	assign o_timer_ext_clk = s.ext_clk;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	property p_lf_sel;
		(s.state == ST_RUN && s.src_code[3:1] == SRC_CODE_LF_HI)
			|-> (s.src == SRC_LF);
	endproperty
	a_lf_sel: assert property (p_lf_sel)
		else $error("Low-frequency crystal not selected");

	property p_lf_rst_ck;
		(load_st && i_clock_source_select_fuses[3:1] == SRC_CODE_LF_HI)
			|-> (ck_value == CNT_W'(RST_CK_LF));
	endproperty
	a_lf_rst_ck: assert property (p_lf_rst_ck)
		else $error("Wrong low-frequency reset cycle count");

	property p_lf_wake;
		(sleep_st && !i_power_down && s.src == SRC_LF)
			|-> (ck_value == (s.src_code[0] ? P_WAKE_LONG_CK
				: CNT_W'(WAKE_CK_LF_SHORT)));
	endproperty
	a_lf_wake: assert property (p_lf_wake)
		else $error("Wrong low-frequency wake count");

	property p_rc_sel;
		(s.state == ST_RUN && s.src_code == SRC_CODE_RC) |-> (s.src == SRC_RC);
	endproperty
	a_rc_sel: assert property (p_rc_sel)
		else $error("RC oscillator not selected");

	// The release edge still shows the reset state, so it is skipped
	property p_trim_load;
		(load_st && i_resetn) |=> (o_osc_trim == $past(i_factory_cal));
	endproperty
	a_trim_load: assert property (p_trim_load)
		else $error("Calibration byte not loaded at reset");

	property p_trim_write;
		(wr && s.a_addr == ADDR_OSC_TRIM && !load_st)
			|=> (o_osc_trim == $past(i_hwdata[7:0]));
	endproperty
	a_trim_write: assert property (p_trim_write)
		else $error("Trim write did not reach oscillator");

	property p_rstdis_tout;
		(load_st && i_reset_pin_disable_fuse
			&& i_startup_time_fuses == STARTUP_SHORT
			&& i_clock_source_select_fuses[3:1] != SRC_CODE_LF_HI)
			|-> (tout_value == P_TOUT_SHORT_CYC);
	endproperty
	a_rstdis_tout: assert property (p_rstdis_tout)
		else $error("Reset delay not stretched with reset pin disabled");

	property p_ext_sel;
		(s.state == ST_RUN && s.src_code == SRC_CODE_EXT)
			|-> (s.src == SRC_EXT);
	endproperty
	a_ext_sel: assert property (p_ext_sel)
		else $error("External clock not selected");

	property p_clkout;
		i_clock_output_fuse
			|-> (!o_clock_output_pin_oe_n && o_clock_output_pin == pin_clk);
	endproperty
	a_clkout: assert property (p_clkout)
		else $error("Clock output pin not driven by system clock");

	property p_timer_rc;
		o_timer_osc_en |-> (o_source_sel == SRC_RC);
	endproperty
	a_timer_rc: assert property (p_timer_rc)
		else $error("Timer oscillator enabled without RC source");

	property p_ps_init;
		(load_st && i_resetn) |=> (s.ps == ($past(i_divide_by_eight_fuse)
			? PS_FUSE_DIV8 : PS_DIV1));
	endproperty
	a_ps_init: assert property (p_ps_init)
		else $error("Prescale select wrong after reset");

	sequence s_startup_elapsed;
		ck_done && tout_done;
	endsequence

	property p_release;
		(s.state == ST_DELAY && !(ck_done && tout_done)) |=> !o_internal_reset_n;
	endproperty
	a_release: assert property (p_release)
		else $error("Internal reset released early");

	property p_release_when;
		(s.state == ST_DELAY) ##0 s_startup_elapsed |=> o_internal_reset_n;
	endproperty
	a_release_when: assert property (p_release_when)
		else $error("Internal reset not released");
endmodule : cssc_clock_startup
`default_nettype wire

// File: verification/cssc_osc_model.sv
// Far-side model: watchdog oscillator ticks and factory calibration byte
`timescale 1ns/1ns
`default_nettype none
module cssc_osc_model #(
	parameter int TICK_DIV = 2,
	parameter logic [7:0] CAL = 8'h3c
) (
	input wire logic i_ref_clk,
	output logic o_wdt_osc_tick,
	output logic [7:0] o_factory_cal
);
	int cnt = 0;
	// Free-running and steady, whatever system source is chosen
	always @(posedge i_ref_clk) begin
		cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
	end
	assign o_wdt_osc_tick = (cnt == 0);
	assign o_factory_cal = CAL;
endmodule : cssc_osc_model
`default_nettype wire

// File: verification/tb.sv
// Testbench for the clock source and start-up control block
`timescale 1ns/1ns
`default_nettype none
module tb
	import cssc_pkg::*;
;
	localparam logic [7:0] CAL = 8'h3c;
	typedef struct packed {
		logic [3:0] sel;
		logic [1:0] su;
		logic dis;
		logic [3:0] src;
		int dly;
		int wake;
	} cssc_tb_cfg_t;
	logic clk, resetn, hsel, hwrite, div8, dis, cko, pd, port_out, port_oe_n;
	logic hready, hresp, tick, irst_n, sclk_en, pin, pin_oe_n, tosc_en, text;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, su_f;
	logic [3:0] sel, src;
	logic [2:0] hsize;
	logic [7:0] cal, trim;
	int miscompares = 0;
	int tests_run = 0;
	int n, p, prev;
	cssc_tb_cfg_t cfg [11];
	// Watchdog ticks come every second cycle, the model's default
	cssc_osc_model #(.CAL(CAL)) u_osc (.i_ref_clk(clk),
		.o_wdt_osc_tick(tick), .o_factory_cal(cal));
	cssc_clock_startup #(.P_TOUT_SHORT_CYC(24'd20), .P_TOUT_LONG_CYC(24'd40),
		.P_TOUT_128K_SHORT_CYC(24'd18), .P_TOUT_128K_LONG_CYC(24'd36),
		.P_WAKE_LONG_CK(24'd50)) DUT (.i_ref_clk(clk), .i_resetn(resetn),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_clock_source_select_fuses(sel), .i_startup_time_fuses(su_f),
		.i_divide_by_eight_fuse(div8), .i_reset_pin_disable_fuse(dis),
		.i_clock_output_fuse(cko), .i_factory_cal(cal),
		.i_wdt_osc_tick(tick), .i_power_down(pd), .i_port_out(port_out),
		.i_port_oe_n(port_oe_n), .o_source_sel(src), .o_osc_trim(trim),
		.o_internal_reset_n(irst_n), .o_sys_clk_en(sclk_en),
		.o_clock_output_pin(pin), .o_clock_output_pin_oe_n(pin_oe_n),
		.o_timer_osc_en(tosc_en), .o_timer_ext_clk(text));
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task check_rng(input string nm, input int v, input int lo, input int hi);
		tests_run++;
		if (v < lo || v > hi) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask : check_rng
	// Single AHB-Lite word transfer; read data lands in r
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb
	task do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		n = 0;
	endtask : do_reset
	task wait_rel;
		do begin
			@(negedge clk);
			n++;
		end while (irst_n !== 1'b1);
	endtask : wait_rel
	task period(output int q);
		q = 0;
		do @(negedge clk); while (sclk_en !== 1'b1);
		do begin
			@(negedge clk);
			q++;
		end while (sclk_en !== 1'b1);
	endtask : period
	task pin_half(output int q);
		logic v;
		q = 0;
		@(negedge clk);
		v = pin;
		do @(negedge clk); while (pin === v);
		v = pin;
		do begin
			@(negedge clk);
			q++;
		end while (pin === v);
	endtask : pin_half
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		miscompares++;
		print_verdict();
	end
	initial begin
		resetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, dis, div8, cko, pd, port_out} = '0;
		hsize = 3'h2;
		sel = 4'h2;
		su_f = 2'h0;
		port_oe_n = 1'b1;
		cfg = '{'{4'h2, 2'h0, 1'b0, 4'h2, 16, 6}, '{4'h2, 2'h1, 1'b0, 4'h2, 40, 6},
			'{4'h2, 2'h2, 1'b0, 4'h2, 80, 6}, '{4'h2, 2'h0, 1'b1, 4'h2, 40, 6},
			'{4'h3, 2'h1, 1'b0, 4'h4, 36, 6}, '{4'h3, 2'h2, 1'b0, 4'h4, 72, 6},
			'{4'h0, 2'h0, 1'b0, 4'h1, 16, 6}, '{4'h0, 2'h2, 1'b0, 4'h1, 80, 6},
			'{4'h6, 2'h0, 1'b1, 4'h8, 6, 1024}, '{4'h7, 2'h1, 1'b0, 4'h8, 40, 50},
			'{4'h5, 2'h3, 1'b0, 4'h2, 80, 6}};
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("src_rst", src, 4'h2);
		check("trim_rst", trim, TRIM_RST);
		check("irst_rst", irst_n, 1'b0);
		check("hresp", hresp, 1'b0);
		foreach (cfg[i]) begin
			@(posedge clk);
			sel <= cfg[i].sel;
			su_f <= cfg[i].su;
			dis <= cfg[i].dis;
			do_reset();
			wait_rel();
			check_rng("release", n, cfg[i].dly - 3, cfg[i].dly + 4);
			check("source", src, cfg[i].src);
			ahb(1'b0, ADDR_STATUS, 32'h0);
			check("status", r[4:0], {1'b1, cfg[i].src});
			ahb(1'b0, ADDR_OSC_TRIM, 32'h0);
			check("trim_cal", r, {24'h0, CAL});
			ahb(1'b1, ADDR_ASYNC, 32'h3);
			@(negedge clk);
			check("tosc_en", tosc_en, cfg[i].src == 4'h2);
			check("tosc_ext", text, 1'b1);
			period(p);
			check("div1", p, 1);
			@(posedge clk);
			pd <= 1'b1;
			repeat (3) @(negedge clk);
			check("asleep", sclk_en, 1'b0);
			@(posedge clk);
			pd <= 1'b0;
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (sclk_en !== 1'b1);
			check_rng("wake", n, cfg[i].wake - 1, cfg[i].wake + 3);
		end
		ahb(1'b1, ADDR_OSC_TRIM, 32'h5a);
		ahb(1'b0, ADDR_OSC_TRIM, 32'h0);
		check("trim_rd", r, 32'h5a);
		check("trim_out", trim, 8'h5a);
		ahb(1'b1, 8'h10, 32'hffffffff);
		ahb(1'b0, 8'h10, 32'h0);
		check("unmapped", r, 32'h0);
		// Divide-by-eight start with the clock pin enabled during the delay
		@(posedge clk);
		{sel, su_f, dis, div8, cko} <= {4'h2, 2'h2, 1'b0, 1'b1, 1'b1};
		do_reset();
		repeat (30) @(negedge clk);
		check("in_delay", irst_n, 1'b0);
		pin_half(p);
		check("pin_rst", p, 8);
		check("pin_oe", pin_oe_n, 1'b0);
		wait_rel();
		ahb(1'b0, ADDR_PRESCALE, 32'h0);
		check("ps_rst", r[3:0], PS_FUSE_DIV8);
		prev = 8;
		for (int k = 0; k <= 8; k++) begin
			ahb(1'b1, ADDR_PRESCALE, 32'h80);
			ahb(1'b1, ADDR_PRESCALE, k);
			period(p);
			check_rng("switch", p, (prev < (1 << k)) ? prev : (1 << k), 512);
			period(p);
			check("div", p, 1 << k);
			pin_half(p);
			check("pin_div", p, 1 << k);
			prev = 1 << k;
		end
		ahb(1'b1, ADDR_PRESCALE, 32'h2);
		ahb(1'b1, ADDR_PRESCALE, 32'h81);
		ahb(1'b1, ADDR_PRESCALE, 32'h2);
		ahb(1'b1, ADDR_PRESCALE, 32'h80);
		repeat (6) @(posedge clk);
		ahb(1'b1, ADDR_PRESCALE, 32'h2);
		ahb(1'b0, ADDR_PRESCALE, 32'h0);
		check("ps_kept", r[3:0], PS_MAX);
		period(p);
		check("div_kept", p, 256);
		@(posedge clk);
		{cko, port_out, port_oe_n} <= 3'b010;
		@(negedge clk);
		check("port_pin", {pin, pin_oe_n}, 2'b10);
		@(posedge clk);
		{port_out, port_oe_n} <= 2'b01;
		@(negedge clk);
		check("port_pin2", {pin, pin_oe_n}, 2'b01);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
